// *** sccr_pkg.sv ***
// shared constants and types for the system clock control register bank
`default_nettype none
package sccr_pkg;

   // i/o word addresses of the bank
   localparam logic [15:0] ADDR_OSC_CPU_CLK   = 16'hff00;
   localparam logic [15:0] ADDR_WATCHDOG      = 16'hff01;
   localparam logic [15:0] ADDR_REG_BOOSTER   = 16'hff02;
   localparam logic [15:0] ADDR_REG_LOAD      = 16'hff03;
   localparam logic [15:0] ADDR_DETECT_LEVEL  = 16'hff04;
   localparam logic [15:0] ADDR_DETECT_CTRL   = 16'hff05;
   localparam logic [15:0] ADDR_CLK_OUT_SEL   = 16'hff10;
   localparam logic [15:0] ADDR_NOISE_REJECT  = 16'hff11;
   localparam logic [15:0] ADDR_LCD_CLK_SEL   = 16'hff12;
   localparam logic [15:0] ADDR_SERIAL_CLK    = 16'hff14;
   localparam logic [15:0] ADDR_CONV_CLK      = 16'hff15;
   localparam logic [15:0] ADDR_CLK_GATES     = 16'hff16;
   localparam logic [15:0] ADDR_TIMER_CLK0    = 16'hff18;

   // number of programmable timer count-clock selects
   localparam int          TIMER_CHANNELS     = 2;

   // bit positions inside the 4-bit words
   localparam int          BIT_CPU_CLK_SRC    = 3;
   localparam int          BIT_FAST_OSC_EN    = 2;
   localparam int          BIT_WD_ENABLE      = 1;
   localparam int          BIT_WD_RESTART     = 0;
   localparam int          BIT_DETECT_RESULT  = 1;
   localparam int          BIT_DETECT_ENABLE  = 0;

   // value read from unused bits and unmapped words
   localparam logic [3:0]  READ_ZERO          = 4'h0;

   // synchroniser depth for the comparator level
   localparam int          SYNC_STAGES        = 2;

   // control fields held by the bank
   typedef struct packed {
      logic                   cpu_clock_source_sel;
      logic                   fast_osc_enable;
      logic                   watchdog_enable_bit;
      logic                   spare_bit_a;
      logic                   regulator_source_sel;
      logic                   halver_mode_on;
      logic                   booster_mode_on;
      logic                   lcd_reg_heavy_load;
      logic                   core_reg_heavy_load;
      logic                   spare_bit_b;
      logic                   lcd_regulator_on;
      logic [3:0]             detect_threshold;
      logic                   detector_enable;
      logic [3:0]             clock_output_pin_sel;
      logic [1:0]             noise_reject_clock_sel_p4;
      logic [1:0]             noise_reject_clock_sel_p1;
      logic [1:0]             lcd_boost_clock_sel;
      logic [2:0]             serial_clock_sel;
      logic [2:0]             converter_clock_sel;
      logic                   multiplier_clock_gate;
      logic                   sound_clock_gate;
      logic                   stopwatch_clock_gate;
      logic                   clock_timer_gate;
      logic [TIMER_CHANNELS-1:0][3:0] timer_count_clock_sel;
   } sccr_ctrl_t;

   // values after initial reset
   localparam sccr_ctrl_t CTRL_RESET =
      '{watchdog_enable_bit: 1'h1, default: '0};
   localparam logic       DETECT_RESULT_RESET = 1'h0;

endpackage : sccr_pkg
`default_nettype wire

// *** sccr_sync.sv ***
// two-stage level synchroniser
`default_nettype none
module sccr_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // level in and out
   input  wire logic async_in,
   output var  logic sync_out
);

   logic [sccr_pkg::SYNC_STAGES-1:0] stage_q;

   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[0], async_in};
      end
   end

   assign sync_out = stage_q[sccr_pkg::SYNC_STAGES-1];

endmodule : sccr_sync
`default_nettype wire

// *** sccr_regs.sv ***
// system clock control register bank on the cpu data-memory bus
`default_nettype none
module sccr_regs (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // cpu data-memory access
   input  wire logic [15:0]       mem_addr,
   input  wire logic              mem_wr,
   input  wire logic              mem_rd,
   input  wire logic [3:0]        mem_wdata,
   output var  logic [3:0]        mem_rdata,
   // analog detector comparator, high while supply is low
   input  wire logic              detect_compare,
   // control fields to the clock and power logic
   output var  sccr_pkg::sccr_ctrl_t ctrl,
   output var  logic              detect_result,
   output var  logic              watchdog_restart
);

   // whole module state
   typedef struct packed {
      sccr_pkg::sccr_ctrl_t ctrl;
      logic                 detect_result;
      logic                 watchdog_restart;
      logic [3:0]           rdata;
   } sccr_state_t;

   sccr_state_t state_q;
   sccr_state_t state_d;
   logic        compare_sync;
   logic [3:0]  read_word;

   // comparator level crosses into sys_clk
   sccr_sync u_compare_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in (detect_compare),
      .sync_out (compare_sync)
   );

   // read multiplexer over the word map
   always_comb begin
      read_word = sccr_pkg::READ_ZERO;
      unique case (mem_addr)
         sccr_pkg::ADDR_OSC_CPU_CLK: begin
            read_word = {state_q.ctrl.cpu_clock_source_sel,
                         state_q.ctrl.fast_osc_enable, 2'h0};
         end
         sccr_pkg::ADDR_WATCHDOG: begin
            read_word = {2'h0, state_q.ctrl.watchdog_enable_bit, 1'h0};
         end
         sccr_pkg::ADDR_REG_BOOSTER: begin
            read_word = {state_q.ctrl.spare_bit_a,
                         state_q.ctrl.regulator_source_sel,
                         state_q.ctrl.halver_mode_on,
                         state_q.ctrl.booster_mode_on};
         end
         sccr_pkg::ADDR_REG_LOAD: begin
            read_word = {state_q.ctrl.lcd_reg_heavy_load,
                         state_q.ctrl.core_reg_heavy_load,
                         state_q.ctrl.spare_bit_b,
                         state_q.ctrl.lcd_regulator_on};
         end
         sccr_pkg::ADDR_DETECT_LEVEL: begin
            read_word = state_q.ctrl.detect_threshold;
         end
         sccr_pkg::ADDR_DETECT_CTRL: begin
            read_word = {2'h0, state_q.detect_result,
                         state_q.ctrl.detector_enable};
         end
         sccr_pkg::ADDR_CLK_OUT_SEL: begin
            read_word = state_q.ctrl.clock_output_pin_sel;
         end
         sccr_pkg::ADDR_NOISE_REJECT: begin
            read_word = {state_q.ctrl.noise_reject_clock_sel_p4,
                         state_q.ctrl.noise_reject_clock_sel_p1};
         end
         sccr_pkg::ADDR_LCD_CLK_SEL: begin
            read_word = {2'h0, state_q.ctrl.lcd_boost_clock_sel};
         end
         sccr_pkg::ADDR_SERIAL_CLK: begin
            read_word = {1'h0, state_q.ctrl.serial_clock_sel};
         end
         sccr_pkg::ADDR_CONV_CLK: begin
            read_word = {1'h0, state_q.ctrl.converter_clock_sel};
         end
         sccr_pkg::ADDR_CLK_GATES: begin
            read_word = {state_q.ctrl.multiplier_clock_gate,
                         state_q.ctrl.sound_clock_gate,
                         state_q.ctrl.stopwatch_clock_gate,
                         state_q.ctrl.clock_timer_gate};
         end
         default: begin
            for (int i = 0; i < sccr_pkg::TIMER_CHANNELS; i++) begin
               if (mem_addr == sccr_pkg::ADDR_TIMER_CLK0 + 16'(i)) begin
                  read_word = state_q.ctrl.timer_count_clock_sel[i];
               end
            end
         end
      endcase
   end

   // next-state logic for writes, reads and detector
   always_comb begin
      state_d = state_q;
      state_d.watchdog_restart = 1'h0;
      if (mem_rd) begin
         state_d.rdata = read_word;
      end
      if (state_q.ctrl.detector_enable) begin
         state_d.detect_result = compare_sync;
      end
      if (mem_wr) begin
         unique case (mem_addr)
            sccr_pkg::ADDR_OSC_CPU_CLK: begin
               state_d.ctrl.cpu_clock_source_sel =
                  mem_wdata[sccr_pkg::BIT_CPU_CLK_SRC];
               state_d.ctrl.fast_osc_enable =
                  mem_wdata[sccr_pkg::BIT_FAST_OSC_EN];
            end
            sccr_pkg::ADDR_WATCHDOG: begin
               state_d.ctrl.watchdog_enable_bit =
                  mem_wdata[sccr_pkg::BIT_WD_ENABLE];
               // one-cycle restart on write of 1
               state_d.watchdog_restart =
                  mem_wdata[sccr_pkg::BIT_WD_RESTART];
            end
            sccr_pkg::ADDR_REG_BOOSTER: begin
               state_d.ctrl.spare_bit_a          = mem_wdata[3];
               state_d.ctrl.regulator_source_sel = mem_wdata[2];
               state_d.ctrl.halver_mode_on       = mem_wdata[1];
               state_d.ctrl.booster_mode_on      = mem_wdata[0];
            end
            sccr_pkg::ADDR_REG_LOAD: begin
               state_d.ctrl.lcd_reg_heavy_load  = mem_wdata[3];
               state_d.ctrl.core_reg_heavy_load = mem_wdata[2];
               state_d.ctrl.spare_bit_b         = mem_wdata[1];
               state_d.ctrl.lcd_regulator_on    = mem_wdata[0];
            end
            sccr_pkg::ADDR_DETECT_LEVEL: begin
               state_d.ctrl.detect_threshold = mem_wdata;
            end
            sccr_pkg::ADDR_DETECT_CTRL: begin
               state_d.ctrl.detector_enable =
                  mem_wdata[sccr_pkg::BIT_DETECT_ENABLE];
            end
            sccr_pkg::ADDR_CLK_OUT_SEL: begin
               state_d.ctrl.clock_output_pin_sel = mem_wdata;
            end
            sccr_pkg::ADDR_NOISE_REJECT: begin
               state_d.ctrl.noise_reject_clock_sel_p4 = mem_wdata[3:2];
               state_d.ctrl.noise_reject_clock_sel_p1 = mem_wdata[1:0];
            end
            sccr_pkg::ADDR_LCD_CLK_SEL: begin
               state_d.ctrl.lcd_boost_clock_sel = mem_wdata[1:0];
            end
            sccr_pkg::ADDR_SERIAL_CLK: begin
               state_d.ctrl.serial_clock_sel = mem_wdata[2:0];
            end
            sccr_pkg::ADDR_CONV_CLK: begin
               state_d.ctrl.converter_clock_sel = mem_wdata[2:0];
            end
            sccr_pkg::ADDR_CLK_GATES: begin
               state_d.ctrl.multiplier_clock_gate = mem_wdata[3];
               state_d.ctrl.sound_clock_gate      = mem_wdata[2];
               state_d.ctrl.stopwatch_clock_gate  = mem_wdata[1];
               state_d.ctrl.clock_timer_gate      = mem_wdata[0];
            end
            default: begin
               for (int i = 0; i < sccr_pkg::TIMER_CHANNELS; i++) begin
                  if (mem_addr == sccr_pkg::ADDR_TIMER_CLK0 + 16'(i)) begin
                     state_d.ctrl.timer_count_clock_sel[i] = mem_wdata;
                  end
               end
            end
         endcase
      end
   end

   // state register with initial reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q.ctrl             <= sccr_pkg::CTRL_RESET;
         state_q.detect_result    <= sccr_pkg::DETECT_RESULT_RESET;
         state_q.watchdog_restart <= 1'h0;
         state_q.rdata            <= sccr_pkg::READ_ZERO;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs straight from the state register
   assign ctrl             = state_q.ctrl;
   assign detect_result    = state_q.detect_result;
   assign watchdog_restart = state_q.watchdog_restart;
   assign mem_rdata        = state_q.rdata;

   // checks on the bank behaviour
   sequence s_write_to(logic [15:0] a);
      mem_wr && mem_addr == a;
   endsequence

   sequence s_read_of(logic [15:0] a);
      mem_rd && !mem_wr && mem_addr == a;
   endsequence

   property p_reset_defaults;
      @(posedge sys_clk) disable iff (1'h0)
      $rose(resetn) |-> ctrl == sccr_pkg::CTRL_RESET && !detect_result
                        && ctrl.watchdog_enable_bit;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("bank not at defaults after reset");

   property p_restart_pulse;
      @(posedge sys_clk) disable iff (!resetn)
      s_write_to(sccr_pkg::ADDR_WATCHDOG) ##0 mem_wdata[0] |=>
         watchdog_restart ##1 (!watchdog_restart || $past(mem_wr));
   endproperty
   a_restart_pulse: assert property (p_restart_pulse)
      else $error("watchdog restart not a one-cycle pulse");

   property p_restart_reads_zero;
      @(posedge sys_clk) disable iff (!resetn)
      s_read_of(sccr_pkg::ADDR_WATCHDOG) |=>
         mem_rdata == {2'h0, $past(ctrl.watchdog_enable_bit), 1'h0};
   endproperty
   a_restart_reads_zero: assert property (p_restart_reads_zero)
      else $error("watchdog word read wrong");

   property p_wd_enable_write;
      @(posedge sys_clk) disable iff (!resetn)
      s_write_to(sccr_pkg::ADDR_WATCHDOG) |=>
         ctrl.watchdog_enable_bit == $past(mem_wdata[1]);
   endproperty
   a_wd_enable_write: assert property (p_wd_enable_write)
      else $error("watchdog enable not written");

   property p_clkout_write_read;
      @(posedge sys_clk) disable iff (!resetn)
      s_write_to(sccr_pkg::ADDR_CLK_OUT_SEL) ##1 !mem_wr ##1
         s_read_of(sccr_pkg::ADDR_CLK_OUT_SEL) |=>
         mem_rdata == $past(mem_wdata, 3);
   endproperty
   a_clkout_write_read: assert property (p_clkout_write_read)
      else $error("clock output select did not read back");

   property p_unused_read_zero;
      @(posedge sys_clk) disable iff (!resetn)
      s_read_of(sccr_pkg::ADDR_DETECT_CTRL) |=> mem_rdata[3:2] == 2'h0;
   endproperty
   a_unused_read_zero: assert property (p_unused_read_zero)
      else $error("unused detector bits not zero");

   property p_no_write_stable;
      @(posedge sys_clk) disable iff (!resetn)
      !mem_wr |=> $stable(ctrl);
   endproperty
   a_no_write_stable: assert property (p_no_write_stable)
      else $error("control changed without a write");

   property p_serial_top_ignored;
      @(posedge sys_clk) disable iff (!resetn)
      s_write_to(sccr_pkg::ADDR_SERIAL_CLK) |=>
         ctrl.serial_clock_sel == $past(mem_wdata[2:0])
         && $stable(ctrl.converter_clock_sel);
   endproperty
   a_serial_top_ignored: assert property (p_serial_top_ignored)
      else $error("serial select write wrong");

   sequence s_low_supply_held;
      (ctrl.detector_enable && detect_compare)[*4];
   endsequence

   property p_detect_follows;
      @(posedge sys_clk) disable iff (!resetn)
      s_low_supply_held |=> detect_result;
   endproperty
   a_detect_follows: assert property (p_detect_follows)
      else $error("detector result missed low supply");

   property p_detect_held_off;
      @(posedge sys_clk) disable iff (!resetn)
      !ctrl.detector_enable |=> $stable(detect_result);
   endproperty
   a_detect_held_off: assert property (p_detect_held_off)
      else $error("detector result moved while disabled");

endmodule : sccr_regs
`default_nettype wire

// *** sccr_cpu_model.sv ***
// cpu core model issuing data-memory reads and writes to the bank
`default_nettype none
module sccr_cpu_model (
   // clock
   input  wire logic        sys_clk,
   // data-memory bus
   output var  logic [15:0] mem_addr,
   output var  logic        mem_wr,
   output var  logic        mem_rd,
   output var  logic [3:0]  mem_wdata,
   input  wire logic [3:0]  mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial begin
      mem_addr  = 16'h0000;
      mem_wr    = 1'b0;
      mem_rd    = 1'b0;
      mem_wdata = 4'h0;
   end

   // one write, strobe held for a single edge, then data scrambled
   task automatic wr(input logic [15:0] a, input logic [3:0] d,
                     input int idle);
      repeat (idle) @(posedge sys_clk);
      @(posedge sys_clk);
      mem_addr  <= a;
      mem_wdata <= d;
      mem_wr    <= 1'b1;
      @(posedge sys_clk);
      mem_wr    <= 1'b0;
      mem_wdata <= ~d;
      mem_addr  <= ~a;
   endtask : wr

   // one read, data taken once the loading edge has settled
   task automatic rd(input logic [15:0] a, output logic [3:0] d);
      @(posedge sys_clk);
      mem_addr <= a;
      mem_rd   <= 1'b1;
      @(posedge sys_clk);
      mem_rd   <= 1'b0;
      mem_addr <= ~a;
      #1;
      d = mem_rdata;
   endtask : rd

endmodule : sccr_cpu_model
`default_nettype wire

// *** sccr_regs_tb.sv ***
// self-checking bench for the system clock control register bank
`default_nettype none
module sccr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // clock, reset and design pins
   logic                 sys_clk = 1'b0;
   logic                 resetn = 1'b0;
   logic [15:0]          mem_addr;
   logic                 mem_wr;
   logic                 mem_rd;
   logic [3:0]           mem_wdata;
   logic [3:0]           mem_rdata;
   logic                 detect_compare = 1'b0;
   sccr_pkg::sccr_ctrl_t ctrl;
   logic                 detect_result;
   logic                 watchdog_restart;
   // behavioural model state
   logic [15:0]          addr_tab [18];
   logic [3:0]           wmask [18];
   logic [3:0]           mw [18];
   logic                 det;
   logic [31:0]          seed = 32'hf6070dd4;
   int                   failures = 0;
   int                   compares = 0;

   always #2 sys_clk = ~sys_clk;

   sccr_regs sccr_regs_inst (
      .sys_clk(sys_clk), .resetn(resetn), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .detect_compare(detect_compare),
      .ctrl(ctrl), .detect_result(detect_result),
      .watchdog_restart(watchdog_restart)
   );

   sccr_cpu_model sccr_cpu_model_inst (
      .sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
   );

   // verdict and end of run
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [63:0] exp,
                      input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs

   // defaults after initial reset, watchdog on
   task automatic model_reset();
      foreach (mw[i]) mw[i] = 4'h0;
      mw[1] = 4'h2;
      det = 1'b0;
   endtask : model_reset

   // result bit joins the enable bit on read
   function automatic logic [3:0] exp_rd(input int i);
      return (i == 5) ? {2'b00, det, mw[5][0]} : mw[i];
   endfunction : exp_rd

   function automatic sccr_pkg::sccr_ctrl_t exp_ctrl();
      sccr_pkg::sccr_ctrl_t c;
      c = '0;
      {c.cpu_clock_source_sel, c.fast_osc_enable} = mw[0][3:2];
      c.watchdog_enable_bit = mw[1][1];
      {c.spare_bit_a, c.regulator_source_sel} = mw[2][3:2];
      {c.halver_mode_on, c.booster_mode_on} = mw[2][1:0];
      {c.lcd_reg_heavy_load, c.core_reg_heavy_load} = mw[3][3:2];
      {c.spare_bit_b, c.lcd_regulator_on} = mw[3][1:0];
      c.detect_threshold = mw[4];
      c.detector_enable = mw[5][0];
      c.clock_output_pin_sel = mw[6];
      c.noise_reject_clock_sel_p4 = mw[7][3:2];
      c.noise_reject_clock_sel_p1 = mw[7][1:0];
      c.lcd_boost_clock_sel = mw[8][1:0];
      c.serial_clock_sel = mw[9][2:0];
      c.converter_clock_sel = mw[10][2:0];
      {c.multiplier_clock_gate, c.sound_clock_gate} = mw[11][3:2];
      {c.stopwatch_clock_gate, c.clock_timer_gate} = mw[11][1:0];
      c.timer_count_clock_sel[0] = mw[12];
      c.timer_count_clock_sel[1] = mw[13];
      return c;
   endfunction : exp_ctrl

   task automatic do_wr(input int i, input logic [3:0] d, input int idle);
      logic [3:0] v;
      v = d;
      if (i == 8) v[1] = 1'b0;
      sccr_cpu_model_inst.wr(addr_tab[i], v, idle);
      mw[i] = v & wmask[i];
      #1;
      chk("ctrl", 64'(exp_ctrl()), 64'(ctrl));
      chk("restart", 64'(i == 1 && v[0]), 64'(watchdog_restart));
      if (i == 1 && v[0]) begin
         @(posedge sys_clk);
         #1;
         chk("restart end", 64'h0, 64'(watchdog_restart));
      end
   endtask : do_wr

   task automatic rd_chk(input int i);
      logic [3:0] d;
      sccr_cpu_model_inst.rd(addr_tab[i], d);
      chk("read word", 64'(exp_rd(i)), 64'(d));
   endtask : rd_chk

   task automatic check_all();
      for (int i = 0; i < 18; i++) rd_chk(i);
      chk("ctrl all", 64'(exp_ctrl()), 64'(ctrl));
      chk("result", 64'(det), 64'(detect_result));
   endtask : check_all

   task automatic wait_det(input logic e);
      int n;
      n = 0;
      while (detect_result !== e && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      det = e;
      chk("detect", 64'(e), 64'(detect_result));
   endtask : wait_det

   task automatic hold_det(input logic e);
      @(posedge sys_clk);
      detect_compare <= e;
      repeat (8) @(posedge sys_clk);
      #1;
      chk("held result", 64'(det), 64'(detect_result));
   endtask : hold_det

   // hang guard
   initial begin
      #200000;
      failures++;
      end_sim();
   end

   // main sequence
   initial begin
      addr_tab = '{16'hff00, 16'hff01, 16'hff02, 16'hff03, 16'hff04,
                   16'hff05, 16'hff10, 16'hff11, 16'hff12, 16'hff14,
                   16'hff15, 16'hff16, 16'hff18, 16'hff19, 16'hff06,
                   16'hff13, 16'hff17, 16'hff1a};
      wmask = '{4'hc, 4'h2, 4'hf, 4'hf, 4'hf, 4'h1, 4'hf, 4'hf, 4'h3,
                4'h7, 4'h7, 4'hf, 4'hf, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0};
      model_reset();
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      check_all();
      // every code of every word, unmapped words too, bit 1 of ff12 held at 0
      for (int i = 0; i < 18; i++) begin
         for (int v = 0; v < 16; v++) begin
            do_wr(i, 4'(v), 0);
            rd_chk(i);
         end
      end
      // random traffic with random spacing
      for (int k = 0; k < 80; k++) begin
         seed = xs(seed);
         do_wr(int'(seed[8:0]) % 18, seed[15:12], int'(seed[21:20]));
      end
      check_all();
      // detector off: comparator ignored; on: result follows it
      do_wr(5, 4'h0, 0);
      hold_det(1'b1);
      do_wr(5, 4'hf, 0);
      wait_det(1'b1);
      rd_chk(5);
      do_wr(5, 4'h0, 0);
      hold_det(1'b0);
      rd_chk(5);
      do_wr(5, 4'h1, 0);
      wait_det(1'b0);
      // second reset in mid-run
      for (int i = 0; i < 14; i++) do_wr(i, 4'hd, 0);
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      model_reset();
      #1;
      check_all();
      end_sim();
   end

endmodule : sccr_regs_tb
`default_nettype wire
